// [shared/adcseq_defs.vh]
// Constants for the conversion sequencer: offsets, fields, reset values.
// Assumes a 25 MHz ref_clk and a 32-bit Wishbone register bus.
`ifndef ADCSEQ_DEFS_VH
`define ADCSEQ_DEFS_VH
// ==========================================================
// Register byte offsets
`define ADCSEQ_OFF_CTRL      8'h00
`define ADCSEQ_OFF_DELAY     8'h04
`define ADCSEQ_OFF_DONE      8'h08
`define ADCSEQ_OFF_SINGLE    8'h0C
`define ADCSEQ_OFF_REPEAT    8'h10
`define ADCSEQ_OFF_RESULT0   8'h14
`define ADCSEQ_OFF_RESULT15  8'h50
`define ADCSEQ_OFF_IRQ_STAT  8'h60
`define ADCSEQ_OFF_IRQ_EN    8'h64
`define ADCSEQ_OFF_IRQ_CLR   8'h68
// ==========================================================
// Control register bits
`define ADCSEQ_CTRL_ON       0
`define ADCSEQ_CTRL_SINGLE   1
`define ADCSEQ_CTRL_REPEAT   2
`define ADCSEQ_CTRL_PSDIS    3
`define ADCSEQ_CTRL_SRST     4
`define ADCSEQ_CTRL_RDONE    6
`define ADCSEQ_CTRL_SDONE    7
// Interrupt status bits
`define ADCSEQ_IRQ_CHAN      0
`define ADCSEQ_IRQ_SDONE     1
`define ADCSEQ_IRQ_RDONE     2
// ==========================================================
// Reset values and timing
`define ADCSEQ_RST_WORD      32'h0000_0000
`define ADCSEQ_TICK_NS       40000
`define ADCSEQ_CLK_NS        40
`define ADCSEQ_TICK_CYC      (`ADCSEQ_TICK_NS / `ADCSEQ_CLK_NS)
// Prescaler reload, one less than the tick length, sized for the counter
`define ADCSEQ_TICK_LOAD     16'h03E7
`endif

// [hdl/adcseq_result_mem.v]
// Result store: sixteen 10-bit conversion readings.
// Assumes one write port from the sequencer, one registered read port.
module adcseq_result_mem #(
	parameter DW = 10,
	parameter AW = 4
)(
	// Clock
	input  wire          ref_clk,
	input  wire          clk_en,
	// Write port
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	// Read port
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data
);
	// ======================================================
	// Storage
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Write then registered read; no reset so it maps to RAM
	always @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			if (wr_en)
				mem[wr_addr] <= wr_data;
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// [hdl/adcseq_top.v]
// Conversion sequencer for a 16-channel converter with Wishbone registers.
// Assumes the converter core answers each request with conv_done + data.
//
// Design decision made here: the Wishbone interface to the registers.
`include "adcseq_defs.vh"
module adcseq_top #(
	parameter NCH = 16,
	parameter RW  = 10
)(
	// Clock and reset
	input  wire          ref_clk,
	input  wire          nrst,
	input  wire          clk_en,
	// Wishbone slave
	input  wire          wb_cyc_i,
	input  wire          wb_stb_i,
	input  wire          wb_we_i,
	input  wire [7:0]    wb_adr_i,
	input  wire [3:0]    wb_sel_i,
	input  wire [31:0]   wb_dat_i,
	output reg  [31:0]   wb_dat_o,
	output reg           wb_ack_o,
	// Converter core
	output reg           conv_start,
	output reg  [3:0]    conv_chan,
	output reg           core_reset,
	output reg           core_power,
	input  wire          conv_done,
	input  wire [RW-1:0] conv_data,
	// Interrupt
	output wire          irq
);
	// ======================================================
	// States
	localparam ST_IDLE  = 2'b00;
	localparam ST_DELAY = 2'b01;
	localparam ST_PICK  = 2'b10;
	localparam ST_WAIT  = 2'b11;

	// ======================================================
	// Registers
	reg        block_on;
	reg        single_trig;
	reg        repeat_on;
	reg        psave_dis;
	reg        soft_rst;
	reg        single_done;
	reg        repeat_done;
	reg [31:0] conversion_delay;
	reg [15:0] channel_done_flags;
	reg [15:0] single_pass_channel_mask;
	reg [15:0] repeat_pass_channel_mask;
	reg [2:0]  irq_stat;
	reg [2:0]  irq_en;
	reg [1:0]  state;
	reg        pass_is_rpt;
	reg [15:0] pend;
	reg [15:0] tick_cnt;
	reg [15:0] units;
	reg        rd_pend;
	reg        rd_res;
	reg        on_q;

	// ======================================================
	// Bus decode
	wire        acc   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr    = acc & wb_we_i;
	wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] wval  = wb_dat_i & wmask;
	wire        is_res = (wb_adr_i >= `ADCSEQ_OFF_RESULT0) &&
		(wb_adr_i <= `ADCSEQ_OFF_RESULT15) && (wb_adr_i[1:0] == 2'b00);
	wire [7:0]  res_off = wb_adr_i - `ADCSEQ_OFF_RESULT0;
	wire [3:0]  res_idx = res_off[5:2];
	wire [RW-1:0] mem_q;

	// Write strobes
	wire wr_ctrl = wr && (wb_adr_i == `ADCSEQ_OFF_CTRL);
	wire wr_dly  = wr && (wb_adr_i == `ADCSEQ_OFF_DELAY);
	wire wr_done = wr && (wb_adr_i == `ADCSEQ_OFF_DONE);
	wire wr_sgl  = wr && (wb_adr_i == `ADCSEQ_OFF_SINGLE);
	wire wr_rpt  = wr && (wb_adr_i == `ADCSEQ_OFF_REPEAT);
	wire wr_ien  = wr && (wb_adr_i == `ADCSEQ_OFF_IRQ_EN);
	wire wr_iclr = wr && (wb_adr_i == `ADCSEQ_OFF_IRQ_CLR);

	// ======================================================
	// Sequencer events
	wire        tick      = (tick_cnt == 16'h0000);
	// Masks load into pend at pass start, so a late mask write
	// cannot change the channels of a pass already under way
	wire        begin_sgl = (state == ST_IDLE) && block_on && single_trig;
	wire        begin_rpt = (state == ST_DELAY) && repeat_on && block_on &&
		(units == 16'h0000);
	wire        got       = (state == ST_WAIT) && conv_done;
	wire [15:0] got_bit   = got ? (16'h0001 << conv_chan) : 16'h0000;
	wire        pass_end  = got && ((pend & ~got_bit) == 16'h0000);
	wire        empty_end = (state == ST_PICK) && (pend == 16'h0000);

	// Lowest pending channel picked by a priority scan
	reg  [3:0]  next_chan;
	integer     i;
	always @*
	begin
		next_chan = 4'h0;
		for (i = NCH - 1; i >= 0; i = i - 1)
			if (pend[i])
				next_chan = i[3:0];
	end

	// Result store instance
	adcseq_result_mem #(.DW(RW), .AW(4)) u_mem (
		.ref_clk (ref_clk),
		.clk_en  (clk_en),
		.wr_en   (got),
		.wr_addr (conv_chan),
		.wr_data (conv_data),
		.rd_addr (res_idx),
		.rd_data (mem_q)
	);

	// ======================================================
	// Control and configuration registers
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			block_on                 <= 1'b0;
			single_trig              <= 1'b0;
			repeat_on                <= 1'b0;
			psave_dis                <= 1'b0;
			soft_rst                 <= 1'b0;
			conversion_delay         <= `ADCSEQ_RST_WORD;
			single_pass_channel_mask <= 16'h0000;
			repeat_pass_channel_mask <= 16'h0000;
			irq_en                   <= 3'h0;
		end
		else if (clk_en)
		begin
			if (wr_ctrl && wb_sel_i[0])
			begin
				block_on  <= wb_dat_i[`ADCSEQ_CTRL_ON];
				repeat_on <= wb_dat_i[`ADCSEQ_CTRL_REPEAT];
				psave_dis <= wb_dat_i[`ADCSEQ_CTRL_PSDIS];
				soft_rst  <= wb_dat_i[`ADCSEQ_CTRL_SRST];
			end
			// Trigger holds until a pass takes it or soft reset drops it
			if (wr_ctrl && wb_sel_i[0] && wb_dat_i[`ADCSEQ_CTRL_SINGLE])
				single_trig <= 1'b1;
			else if (begin_sgl || soft_rst)
				single_trig <= 1'b0;
			if (wr_dly)
				conversion_delay <= (conversion_delay & ~wmask) | wval;
			if (wr_sgl)
				single_pass_channel_mask <= (single_pass_channel_mask &
					~wmask[15:0]) | wval[15:0];
			if (wr_rpt)
				repeat_pass_channel_mask <= (repeat_pass_channel_mask &
					~wmask[15:0]) | wval[15:0];
			if (wr_ien && wb_sel_i[0])
				irq_en <= wb_dat_i[2:0];
		end
	end

	// ======================================================
	// Sequencer: 40 us prescaler, delay countdown, channel walk
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state       <= ST_IDLE;
			pass_is_rpt <= 1'b0;
			pend        <= 16'h0000;
			tick_cnt    <= 16'h0000;
			units       <= 16'h0000;
			conv_start  <= 1'b0;
			conv_chan   <= 4'h0;
			on_q        <= 1'b0;
			core_reset  <= 1'b0;
		end
		else if (clk_en)
		begin
			on_q       <= block_on;
			// Reset pulse to the core as the block is switched on
			core_reset <= (block_on & ~on_q) | soft_rst;
			conv_start <= 1'b0;
			tick_cnt   <= tick ? `ADCSEQ_TICK_LOAD : tick_cnt - 16'h0001;
			if (soft_rst)
			begin
				state <= ST_IDLE;
				pend  <= 16'h0000;
			end
			else
			begin
				case (state)
				ST_IDLE:
				begin
					if (begin_sgl)
					begin
						pass_is_rpt <= 1'b0;
						pend        <= single_pass_channel_mask;
						state       <= ST_PICK;
					end
					else if (block_on && repeat_on)
					begin
						units    <= conversion_delay[15:0];
						tick_cnt <= `ADCSEQ_TICK_LOAD;
						state    <= ST_DELAY;
					end
				end
				ST_DELAY:
				begin
					// Repeat off or block off drops the timer
					if (!repeat_on || !block_on)
						state <= ST_IDLE;
					else if (begin_rpt)
					begin
						pass_is_rpt <= 1'b1;
						pend        <= repeat_pass_channel_mask;
						state       <= ST_PICK;
					end
					else if (tick)
						units <= units - 16'h0001;
				end
				ST_PICK:
				begin
					if (empty_end)
						state <= ST_IDLE;
					else
					begin
						conv_chan  <= next_chan;
						conv_start <= 1'b1;
						state      <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					if (got)
					begin
						pend <= pend & ~got_bit;
						if (pass_end && pass_is_rpt && repeat_on && block_on)
						begin
							units    <= conversion_delay[31:16];
							tick_cnt <= `ADCSEQ_TICK_LOAD;
							state    <= ST_DELAY;
						end
						else if (pass_end)
							state <= ST_IDLE;
						else
							state <= ST_PICK;
					end
				end
				default:
					state <= ST_IDLE;
				endcase
			end
		end
	end

	// ======================================================
	// Done flags; hardware set wins over software clear
	wire sdone_set = (pass_end || empty_end) && !pass_is_rpt;
	wire rdone_set = (pass_end || empty_end) && pass_is_rpt;
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			channel_done_flags <= 16'h0000;
			single_done        <= 1'b0;
			repeat_done        <= 1'b0;
			irq_stat           <= 3'h0;
		end
		else if (clk_en)
		begin
			// Result lands in memory on the same edge
			channel_done_flags <= (channel_done_flags &
				~(wr_done ? wval[15:0] : 16'h0000)) | got_bit;
			if (sdone_set)
				single_done <= 1'b1;
			else if (begin_sgl)
				single_done <= 1'b0;
			else if (wr_ctrl && wval[`ADCSEQ_CTRL_SDONE])
				single_done <= 1'b0;
			if (rdone_set)
				repeat_done <= 1'b1;
			else if (begin_rpt)
				repeat_done <= 1'b0;
			else if (wr_ctrl && wval[`ADCSEQ_CTRL_RDONE])
				repeat_done <= 1'b0;
			irq_stat <= (irq_stat & ~(wr_iclr ? wval[2:0] : 3'h0)) |
				{rdone_set, sdone_set, got};
		end
	end

	assign irq = |(irq_stat & irq_en);

	// Core powered while on and out of idle, delay countdown included, unless saving is off
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			core_power <= 1'b0;
		else if (clk_en)
			core_power <= block_on & (psave_dis | (state != ST_IDLE));
	end

	// ======================================================
	// Wishbone answer; result reads wait one cycle for the memory
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			rd_pend  <= 1'b0;
			rd_res   <= 1'b0;
		end
		else if (clk_en)
		begin
			wb_ack_o <= 1'b0;
			rd_res   <= 1'b0;
			if (rd_res)
			begin
				wb_dat_o <= {{(32-RW){1'b0}}, mem_q};
				wb_ack_o <= 1'b1;
				rd_pend  <= 1'b0;
			end
			else if (acc && !rd_pend)
			begin
				if (!wb_we_i && is_res)
				begin
					rd_pend <= 1'b1;
					rd_res  <= 1'b1;
				end
				else
				begin
					wb_ack_o <= 1'b1;
					case (wb_adr_i)
					`ADCSEQ_OFF_CTRL:
						wb_dat_o <= {24'h000000, single_done, repeat_done,
							1'b0, soft_rst, psave_dis, repeat_on,
							single_trig, block_on};
					`ADCSEQ_OFF_DELAY:
						wb_dat_o <= conversion_delay;
					`ADCSEQ_OFF_DONE:
						wb_dat_o <= {16'h0000, channel_done_flags};
					`ADCSEQ_OFF_SINGLE:
						wb_dat_o <= {16'h0000, single_pass_channel_mask};
					`ADCSEQ_OFF_REPEAT:
						wb_dat_o <= {16'h0000, repeat_pass_channel_mask};
					`ADCSEQ_OFF_IRQ_STAT:
						wb_dat_o <= {29'h0, irq_stat};
					`ADCSEQ_OFF_IRQ_EN:
						wb_dat_o <= {29'h0, irq_en};
					default:
						wb_dat_o <= 32'h0000_0000;
					endcase
				end
			end
		end
	end
endmodule

// [sim/adcseq_core_model.sv]
// Converter core model: one conversion at a time, prompt or slow.
// Assumes conv_start is a one-cycle pulse on the shared ref_clk.
module adcseq_core_model (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       nrst,
	// Pace select
	input  wire       slow,
	// Converter link
	input  wire       conv_start,
	input  wire [3:0] conv_chan,
	output reg        conv_done,
	output reg  [9:0] conv_data
);
	timeunit 1ns;
	timeprecision 1ps;
	int       left;
	reg [3:0] ch;
	reg [5:0] seq;
	// ==============================
	// Engine
	// Data flips when not valid, so a stale capture never matches
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			left      <= -1;
			ch        <= 4'h0;
			seq       <= 6'h00;
			conv_done <= 1'h0;
			conv_data <= 10'h155;
		end
		else
		begin
			conv_done <= 1'h0;
			conv_data <= ~conv_data;
			if (conv_start)
			begin
				ch   <= conv_chan;
				left <= slow ? 6 : 1;
			end
			else if (left > 0)
				left <= left - 1;
			else if (left == 0)
			begin
				left      <= -1;
				seq       <= seq + 6'h01;
				conv_done <= 1'h1;
				conv_data <= {ch, seq};
			end
		end
	end
endmodule

// [sim/adcseq_monitor.sv]
// Port checker of the sequencer top, bound from the bench top.
// Assumes clk_en high and a master that drops stb between accesses.
`include "adcseq_defs.vh"
module adcseq_monitor #(
	parameter NCH = 16,
	parameter RW  = 10
)(
	// Clock and reset
	input wire          ref_clk,
	input wire          nrst,
	input wire          clk_en,
	// Wishbone slave
	input wire          wb_cyc_i,
	input wire          wb_stb_i,
	input wire          wb_we_i,
	input wire [7:0]    wb_adr_i,
	input wire [3:0]    wb_sel_i,
	input wire [31:0]   wb_dat_i,
	input wire [31:0]   wb_dat_o,
	input wire          wb_ack_o,
	// Converter core
	input wire          conv_start,
	input wire [3:0]    conv_chan,
	input wire          core_reset,
	input wire          core_power,
	input wire          conv_done,
	input wire [RW-1:0] conv_data,
	// Interrupt
	input wire          irq
);
	timeunit 1ns;
	timeprecision 1ps;
	reg       busy;
	reg [2:0] ien;
	wire      rd  = wb_ack_o && !wb_we_i;
	wire      res = !wb_we_i && wb_adr_i >= 8'h14 && wb_adr_i <= 8'h50;
	// Shadows: a request in flight, and the interrupt enables
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy <= 1'h0;
			ien  <= 3'h0;
		end
		else
		begin
			busy <= conv_start | (busy & ~conv_done);
			// Follows the design's write edge, the same edge that raises ack
			if (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
				wb_sel_i[0] && wb_adr_i == `ADCSEQ_OFF_IRQ_EN)
				ien <= wb_dat_i[2:0];
		end
	end
	// ==============================
	// Properties
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_plain: assert property ($rose(wb_stb_i) && !res |=> wb_ack_o)
		else $error("register ack late");
	a_ack_result: assert property ($rose(wb_stb_i) && res
		|=> !wb_ack_o ##1 wb_ack_o) else $error("result ack timing");
	a_result_upper:
		assert property (rd && res |-> wb_dat_o[31:10] == 22'h0)
		else $error("result upper bits set");
	a_reset_idle:
		assert property ($rose(nrst) |-> !conv_start && !irq)
		else $error("not idle after reset");
	a_one_pending: assert property (conv_start |-> !busy)
		else $error("second request in flight");
	a_done_irq:
		assert property (conv_done && ien[0] |-> ##[1:3] irq)
		else $error("channel done raised no irq");
	a_irq_masked: assert property (ien == 3'h0 |-> !irq)
		else $error("irq while masked");
	c_result: cover property (rd && res);
	c_irq: cover property ($rose(irq));
	c_chain: cover property (conv_done ##2 conv_start);
endmodule

// [sim/test_adc_conversion_sequencer.sv]
// Bench of the sequencer: Wishbone tasks, core model, reference log.
// Assumes the designer's register map and a 25 MHz ref_clk.
`include "adcseq_defs.vh"
module test_adc_conversion_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'h0;
	logic        nrst = 1'h0;
	logic        wb_cyc_i = 1'h0;
	logic        wb_stb_i = 1'h0;
	logic        wb_we_i = 1'h0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic        slow = 1'h0;
	logic        clk_en = 1'h1;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [3:0]  sel = 4'hF;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, conv_start, conv_done, irq, core_reset, core_power;
	wire  [3:0]  conv_chan;
	wire  [9:0]  conv_data;
	int          n_errors, cmp_count, cyc, n, t0;
	int          starts[$], dones[$];
	logic [9:0]  exp_res[16];
	logic [15:0] seen, m;
	logic [3:0]  cur;
	logic [31:0] q, d;
	logic [7:0]  offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h64};
	always #20 ref_clk = ~ref_clk;
	adcseq_top DUT (
		.ref_clk, .nrst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.conv_start, .conv_chan, .core_reset, .core_power,
		.conv_done, .conv_data, .irq
	);
	adcseq_core_model u_core (
		.ref_clk, .nrst, .slow, .conv_start, .conv_chan, .conv_done,
		.conv_data
	);
	// Reference log of what the core delivered; hang guard
	always @(posedge ref_clk)
	begin
		cyc++;
		if (conv_start === 1'h1)
		begin
			cur = conv_chan;
			starts.push_back(cyc);
		end
		if (conv_done === 1'h1)
		begin
			exp_res[cur] = conv_data;
			seen[cur] = 1'h1;
			dones.push_back(cyc);
		end
		if (cyc == 30000)
		begin
			n_errors++;
			end_of_test();
		end
	end
	// ==============================
	// Tasks
	// Request held until ack is sampled, then a quiet cycle
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= w;
		wb_sel_i <= sel;
		wb_adr_i <= a;
		wb_dat_i <= v;
		@(posedge ref_clk);
		while (wb_ack_o !== 1'h1)
			@(posedge ref_clk);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] got, e);
		cmp_count++;
		if (got !== e)
		begin
			n_errors++;
			$display("mismatch %s exp %h got %h", nm, e, got);
		end
	endtask
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==============================
	// Main sequence
	initial
	begin
		void'($urandom(84));
		repeat (6) @(posedge ref_clk);
		nrst <= 1'h1;
		@(posedge ref_clk);
		foreach (offs[i])
			rdc("reset", offs[i], 32'h0);
		bus(1'h1, 8'h70, 32'hFFFF_FFFF);
		rdc("unmapped", 8'h70, 32'h0);
		d = $urandom;
		bus(1'h1, `ADCSEQ_OFF_DELAY, d);
		rdc("delay", `ADCSEQ_OFF_DELAY, d);
		// Low two lanes only: the interval half must survive
		sel = 4'h3;
		bus(1'h1, `ADCSEQ_OFF_DELAY, ~d);
		sel = 4'hF;
		rdc("lanes", `ADCSEQ_OFF_DELAY, {d[31:16], ~d[15:0]});
		$display("test registers done");
		// Singles run with the random delay left loaded
		bus(1'h1, `ADCSEQ_OFF_IRQ_EN, 32'h1);
		for (int it = 0; it < 3; it++)
		begin
			m = $urandom | 16'h8001;
			slow <= it[0];
			seen = 16'h0;
			bus(1'h1, `ADCSEQ_OFF_DONE, 32'hFFFF);
			bus(1'h1, `ADCSEQ_OFF_SINGLE, {16'h0, m});
			starts.delete();
			dones.delete();
			bus(1'h1, `ADCSEQ_OFF_CTRL, 32'h3);
			rdc("ctrl_run", `ADCSEQ_OFF_CTRL, 32'h1);
			chk("no_delay", starts.size() > 0, 1);
			do
				bus(1'h0, `ADCSEQ_OFF_CTRL, 32'h0);
			while (q[7] !== 1'h1);
			chk("pass_len", dones.size(), $countones(m));
			chk("converted", seen, m);
			rdc("chan_done", `ADCSEQ_OFF_DONE, {16'h0, m});
			for (int k = 0; k < 16; k++)
				if (m[k])
					rdc("res", 8'(8'h14 + 4 * k), {22'h0, exp_res[k]});
			$display("test single pass done");
		end
		rdc("irq_stat", `ADCSEQ_OFF_IRQ_STAT, 32'h3);
		bus(1'h1, `ADCSEQ_OFF_IRQ_EN, 32'h0);
		chk("irq_masked", irq, 1'h0);
		bus(1'h1, `ADCSEQ_OFF_IRQ_EN, 32'h2);
		chk("irq_on", irq, 1'h1);
		bus(1'h1, `ADCSEQ_OFF_IRQ_CLR, 32'h7);
		chk("irq_clear", irq, 1'h0);
		bus(1'h1, `ADCSEQ_OFF_DONE, 32'h0);
		rdc("w1c_zero", `ADCSEQ_OFF_DONE, {16'h0, m});
		bus(1'h1, `ADCSEQ_OFF_DONE, {16'h0, m & 16'h00FF});
		rdc("w1c_half", `ADCSEQ_OFF_DONE, {16'h0, m & 16'hFF00});
		$display("test interrupt and clear done");
		// Repeat: start delay 2 units, interval 1 unit
		m = $urandom | 16'h0101;
		n = $countones(m);
		seen = 16'h0;
		slow <= 1'h0;
		bus(1'h1, `ADCSEQ_OFF_DELAY, 32'h0001_0002);
		bus(1'h1, `ADCSEQ_OFF_REPEAT, {16'h0, m});
		starts.delete();
		dones.delete();
		bus(1'h1, `ADCSEQ_OFF_CTRL, 32'h5);
		t0 = cyc;
		do
			bus(1'h0, `ADCSEQ_OFF_CTRL, 32'h0);
		while (q[6] !== 1'h1);
		chk("first_wait", (starts[0] - t0) inside {[1900:3100]}, 1);
		chk("rpt_len", dones.size(), n);
		chk("rpt_set", seen, m);
		chk("power_run", core_power, 1'h1);
		// Freeze 500 cycles inside the interval: the gap grows by that much
		clk_en <= 1'h0;
		repeat (500) @(posedge ref_clk);
		clk_en <= 1'h1;
		while (starts.size() <= n)
			@(posedge ref_clk);
		chk("gap", (starts[n] - dones[n - 1]) inside {[1400:2600]}, 1);
		bus(1'h1, `ADCSEQ_OFF_CTRL, 32'h1);
		repeat (3000) @(posedge ref_clk);
		chk("rpt_stop", starts.size(), 2 * n);
		chk("power_save", core_power, 1'h0);
		bus(1'h1, `ADCSEQ_OFF_CTRL, 32'h0);
		bus(1'h1, `ADCSEQ_OFF_CTRL, 32'h2);
		repeat (200) @(posedge ref_clk);
		chk("off_idle", starts.size(), 2 * n);
		// Soft reset drops the pending trigger; then switch on, saver off
		bus(1'h1, `ADCSEQ_OFF_CTRL, 32'h18);
		chk("soft_rst", core_reset, 1'h1);
		bus(1'h1, `ADCSEQ_OFF_CTRL, 32'h9);
		chk("core_rst", core_reset, 1'h1);
		chk("power_keep", core_power, 1'h1);
		repeat (200) @(posedge ref_clk);
		chk("trig_drop", starts.size(), 2 * n);
		$display("test repeat and block off done");
		end_of_test();
	end
endmodule
bind adcseq_top adcseq_monitor #(.NCH(NCH), .RW(RW)) u_mon (
	.ref_clk, .nrst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_start, .conv_chan,
	.core_reset, .core_power, .conv_done, .conv_data, .irq
);
